/* File: hdl/fub_pkg.sv */
package fub_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int AXI_AW = 5;
    localparam logic [2:0] REG_DATA = 3'h0;
    localparam logic [2:0] REG_IER = 3'h1;
    localparam logic [2:0] REG_IIR_FCR = 3'h2;
    localparam logic [2:0] REG_LCR = 3'h3;
    localparam logic [2:0] REG_LSR = 3'h4;
    localparam logic [2:0] REG_DIV = 3'h5;
    localparam logic [2:0] REG_STS = 3'h6;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_DEC = 2'h3;

    // ----------------------------------------------------------------
    // Reset values and field positions
    // ----------------------------------------------------------------
    localparam logic [7:0] LCR_RST = 8'h03;
    localparam logic [15:0] DIV_RST = 16'h0001;
    localparam int LCR_STB = 2;
    localparam int LCR_PEN = 3;
    localparam int LCR_EPS = 4;
    localparam int LCR_STK = 5;
    localparam int LCR_SRC = 7;
    localparam int FCR_EN = 0;
    localparam int FCR_RXR = 1;
    localparam int FCR_TXR = 2;
    localparam int EV_THRE = 0;
    localparam int EV_RXD = 1;
    localparam int EV_TMO = 2;
    localparam int EV_LSE = 3;
    localparam logic [3:0] IIR_NONE = 4'h1;
    localparam logic [3:0] IIR_LSE = 4'h6;
    localparam logic [3:0] IIR_RXD = 4'h4;
    localparam logic [3:0] IIR_TMO = 4'hC;
    localparam logic [3:0] IIR_THRE = 4'h2;

    // ----------------------------------------------------------------
    // Timing in 16x ticks, FIFO depth and trigger levels
    // ----------------------------------------------------------------
    localparam int FIFO_DEPTH = 16;
    localparam logic [4:0] TK_LAST = 5'h0F;
    localparam logic [4:0] TK_MID = 5'h07;
    localparam logic [4:0] STOP1_LAST = 5'h0F;
    localparam logic [4:0] STOP15_LAST = 5'h17;
    localparam logic [4:0] STOP2_LAST = 5'h1F;
    localparam logic [9:0] TMO_TICKS = 10'h280;
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0E;

    typedef enum logic [2:0] {
        SER_IDLE = 3'b000,
        SER_START = 3'b001,
        SER_DATA = 3'b011,
        SER_PAR = 3'b010,
        SER_STOP = 3'b110
    } fub_ser_e;

    typedef struct packed {
        logic awv;
        logic wv;
        logic [2:0] awa;
        logic [15:0] wd;
        logic [1:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] lcr;
        logic [3:0] ier;
        logic fen;
        logic [1:0] trig;
        logic [15:0] div;
        logic [3:0] sts;
        logic oe;
        logic pe;
        logic fe;
        logic [15:0] bcnt;
        logic [FIFO_DEPTH-1:0][7:0] txf;
        logic [3:0] txw;
        logic [3:0] txr;
        logic [4:0] txn;
        fub_ser_e tx_st;
        logic [4:0] tx_tk;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic txd;
        logic [FIFO_DEPTH-1:0][7:0] rxf;
        logic [3:0] rxw;
        logic [3:0] rxr;
        logic [4:0] rxn;
        fub_ser_e rx_st;
        logic [4:0] rx_tk;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_h;
        logic rx_f;
        logic [9:0] tmo;
    } fub_st_s;

endpackage

/* File: hdl/fub_uart.sv */
// Operation
// - Baud source selectable, 24 or 16 MHz.
// - 24 MHz source gives 50 to 115.2k.
// - 16 MHz source gives 125k to 1000k.
// - One start bit, five to eight data.
// - Stop length one, one and a half or two.
// - Even, odd, sticky or no parity.
// - Sixteen-bit divisor, values 1 to 65535.
// - Holding register write starts framed transmission.
// - Start, data LSB first, parity, stop; /16.
// - Transmit empty raises holding-empty interrupt.
// - FIFO control bit 0 enables 16-byte FIFOs.
// - FIFO mode sends back to back.
// - Receiver samples at sixteen times baud.
// - Reject pulses under two receive clocks.
// - First bit into bit 0; check parity, stop.
// - Receive interrupt on byte or trigger level.
// - Timeout, parity, framing, overrun interrupts.
// - Receive FIFO 16 bytes, trigger 1/4/8/14.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
module fub_uart
    import fub_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Baud source strobes
    input wire logic src24_tick,
    input wire logic src16_tick,
    // Serial line
    input wire logic rxd,
    output logic txd,
    // Interrupt
    output logic irq
);

    fub_st_s q;
    fub_st_s n;
    logic tick;
    logic [2:0] wl_last;
    logic [7:0] wmask;
    logic [4:0] stop_last;
    logic [4:0] lim;
    logic [4:0] trig_lvl;
    logic [3:0] pend;
    logic [3:0] iir;
    logic tx_push;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic [7:0] rx_byte;
    logic par_exp;
    logic tx_flush;
    logic rx_flush;

    // ----------------------------------------------------------------
    // Bus handshakes and outputs
    // ----------------------------------------------------------------
    assign s_axi_awready = !q.awv && !q.bvalid;
    assign s_axi_wready = !q.wv && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rresp = q.rresp;
    assign s_axi_rdata = q.rdata;
    assign txd = q.txd;
    assign pend = q.sts & q.ier;
    assign irq = |pend;

    // ----------------------------------------------------------------
    // Frame format decode
    // ----------------------------------------------------------------
    assign wl_last = {1'b1, q.lcr[1:0]};
    assign wmask = 8'hFF >> (2'h3 - q.lcr[1:0]);
    assign lim = q.fen ? 5'(FIFO_DEPTH) : 5'h01;

    always_comb
    begin
        if (!q.lcr[LCR_STB])
        begin
            stop_last = STOP1_LAST;
        end
        else if (q.lcr[1:0] == 2'h0)
        begin
            stop_last = STOP15_LAST;
        end
        else
        begin
            stop_last = STOP2_LAST;
        end
        case (q.trig)
            2'h0: trig_lvl = TRIG_L0;
            2'h1: trig_lvl = TRIG_L1;
            2'h2: trig_lvl = TRIG_L2;
            default: trig_lvl = TRIG_L3;
        endcase
        if (pend[EV_LSE])
        begin
            iir = IIR_LSE;
        end
        else if (pend[EV_RXD])
        begin
            iir = IIR_RXD;
        end
        else if (pend[EV_TMO])
        begin
            iir = IIR_TMO;
        end
        else if (pend[EV_THRE])
        begin
            iir = IIR_THRE;
        end
        else
        begin
            iir = IIR_NONE;
        end
    end

    // Baud generator: selected source divided by divisor gives 16x tick
    always_comb
    begin
        tick = (q.lcr[LCR_SRC] ? src16_tick : src24_tick)
            && (q.div == 16'h0000 || q.bcnt >= q.div - 16'h0001);
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        n = q;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_flush = 1'b0;
        rx_flush = 1'b0;
        rx_byte = q.rx_sh >> (3'h7 - wl_last);
        par_exp = q.lcr[LCR_STK] ? !q.lcr[LCR_EPS] : (^(q.rx_sh & 8'hFF) ^ !q.lcr[LCR_EPS]);

        // Baud counter
        if (q.lcr[LCR_SRC] ? src16_tick : src24_tick)
        begin
            n.bcnt = tick ? 16'h0000 : q.bcnt + 16'h0001;
        end

        // Write channel
        if (s_axi_awvalid && s_axi_awready)
        begin
            n.awv = 1'b1;
            n.awa = s_axi_awaddr[4:2];
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            n.wv = 1'b1;
            n.wd = s_axi_wdata[15:0];
            n.ws = s_axi_wstrb[1:0];
        end
        if (q.bvalid && s_axi_bready)
        begin
            n.bvalid = 1'b0;
        end
        if (q.awv && q.wv && !q.bvalid)
        begin
            n.awv = 1'b0;
            n.wv = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OK;
            case (q.awa)
                REG_DATA:
                begin
                    tx_push = q.ws[0] && q.txn < lim;
                end
                REG_IER:
                begin
                    if (q.ws[0])
                    begin
                        n.ier = q.wd[3:0];
                    end
                end
                REG_IIR_FCR:
                begin
                    if (q.ws[0])
                    begin
                        n.fen = q.wd[FCR_EN];
                        n.trig = q.wd[7:6];
                        rx_flush = q.wd[FCR_RXR] || q.wd[FCR_EN] != q.fen;
                        tx_flush = q.wd[FCR_TXR] || q.wd[FCR_EN] != q.fen;
                    end
                end
                REG_LCR:
                begin
                    if (q.ws[0])
                    begin
                        n.lcr = q.wd[7:0];
                    end
                end
                REG_DIV:
                begin
                    if (q.ws[0])
                    begin
                        n.div[7:0] = q.wd[7:0];
                    end
                    if (q.ws[1])
                    begin
                        n.div[15:8] = q.wd[15:8];
                    end
                end
                REG_LSR, REG_STS:
                begin
                end
                default:
                begin
                    n.bresp = RESP_DEC;
                end
            endcase
        end

        // Read channel, with read side effects
        if (q.rvalid && s_axi_rready)
        begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready)
        begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OK;
            n.rdata = 32'h0000_0000;
            case (s_axi_araddr[4:2])
                REG_DATA:
                begin
                    n.rdata[7:0] = q.rxf[q.rxr];
                    rx_pop = q.rxn != 5'h00;
                end
                REG_IER: n.rdata[3:0] = q.ier;
                REG_IIR_FCR: n.rdata[7:0] = {{2{q.fen}}, 2'h0, iir};
                REG_LCR: n.rdata[7:0] = q.lcr;
                REG_LSR:
                begin
                    n.rdata[7:0] = {1'b0, q.txn == 5'h00 && q.tx_st == SER_IDLE,
                        q.txn == 5'h00, 1'b0, q.fe, q.pe, q.oe, q.rxn != 5'h00};
                    n.oe = 1'b0;
                    n.pe = 1'b0;
                    n.fe = 1'b0;
                end
                REG_DIV: n.rdata[15:0] = q.div;
                REG_STS:
                begin
                    n.rdata[3:0] = q.sts;
                    n.sts = 4'h0;
                end
                default: n.rresp = RESP_DEC;
            endcase
        end

        // Transmitter
        case (q.tx_st)
            SER_IDLE:
            begin
                n.txd = 1'b1;
                if (q.txn != 5'h00)
                begin
                    tx_pop = 1'b1;
                    n.tx_sh = q.txf[q.txr] & wmask;
                    n.tx_par = q.lcr[LCR_STK] ? !q.lcr[LCR_EPS]
                        : (^(q.txf[q.txr] & wmask) ^ !q.lcr[LCR_EPS]);
                    n.tx_tk = 5'h00;
                    n.tx_st = SER_START;
                end
            end
            SER_START:
            begin
                n.txd = 1'b0;
                if (tick)
                begin
                    n.tx_tk = q.tx_tk + 5'h01;
                    if (q.tx_tk == TK_LAST)
                    begin
                        n.tx_tk = 5'h00;
                        n.tx_bit = 3'h0;
                        n.tx_st = SER_DATA;
                    end
                end
            end
            SER_DATA:
            begin
                n.txd = q.tx_sh[0];
                if (tick)
                begin
                    n.tx_tk = q.tx_tk + 5'h01;
                    if (q.tx_tk == TK_LAST)
                    begin
                        n.tx_tk = 5'h00;
                        n.tx_sh = q.tx_sh >> 1;
                        n.tx_bit = q.tx_bit + 3'h1;
                        if (q.tx_bit == wl_last)
                        begin
                            n.tx_st = q.lcr[LCR_PEN] ? SER_PAR : SER_STOP;
                        end
                    end
                end
            end
            SER_PAR:
            begin
                n.txd = q.tx_par;
                if (tick)
                begin
                    n.tx_tk = q.tx_tk + 5'h01;
                    if (q.tx_tk == TK_LAST)
                    begin
                        n.tx_tk = 5'h00;
                        n.tx_st = SER_STOP;
                    end
                end
            end
            SER_STOP:
            begin
                n.txd = 1'b1;
                if (tick)
                begin
                    n.tx_tk = q.tx_tk + 5'h01;
                    if (q.tx_tk == stop_last)
                    begin
                        n.tx_st = SER_IDLE;
                    end
                end
            end
            default: n.tx_st = SER_IDLE;
        endcase

        // Receive filter: level changes only after two equal samples
        if (tick)
        begin
            n.rx_h = rxd;
            if (rxd == q.rx_h)
            begin
                n.rx_f = rxd;
            end
        end

        // Receiver
        if (tick)
        begin
            n.rx_tk = q.rx_tk + 5'h01;
            case (q.rx_st)
                SER_IDLE:
                begin
                    n.rx_tk = 5'h00;
                    if (!q.rx_f)
                    begin
                        n.rx_st = SER_START;
                    end
                end
                SER_START:
                begin
                    if (q.rx_tk == TK_MID)
                    begin
                        n.rx_tk = 5'h00;
                        n.rx_bit = 3'h0;
                        n.rx_sh = 8'h00;
                        n.rx_st = q.rx_f ? SER_IDLE : SER_DATA;
                    end
                end
                SER_DATA:
                begin
                    if (q.rx_tk == TK_LAST)
                    begin
                        n.rx_tk = 5'h00;
                        n.rx_sh = {q.rx_f, q.rx_sh[7:1]};
                        n.rx_bit = q.rx_bit + 3'h1;
                        if (q.rx_bit == wl_last)
                        begin
                            n.rx_st = q.lcr[LCR_PEN] ? SER_PAR : SER_STOP;
                        end
                    end
                end
                SER_PAR:
                begin
                    if (q.rx_tk == TK_LAST)
                    begin
                        n.rx_tk = 5'h00;
                        if (q.rx_f != par_exp)
                        begin
                            n.pe = 1'b1;
                        end
                        n.rx_st = SER_STOP;
                    end
                end
                SER_STOP:
                begin
                    if (q.rx_tk == TK_LAST)
                    begin
                        if (!q.rx_f)
                        begin
                            n.fe = 1'b1;
                        end
                        if (q.rxn - 5'(rx_pop) < lim)
                        begin
                            rx_push = 1'b1;
                        end
                        else
                        begin
                            n.oe = 1'b1;
                        end
                        n.rx_st = SER_IDLE;
                    end
                end
                default: n.rx_st = SER_IDLE;
            endcase
        end

        // FIFO pointers
        if (tx_push)
        begin
            n.txf[q.txw] = q.wd[7:0];
            n.txw = q.txw + 4'h1;
        end
        if (tx_pop)
        begin
            n.txr = q.txr + 4'h1;
        end
        n.txn = q.txn + 5'(tx_push) - 5'(tx_pop);
        n.rxn = q.rxn + 5'(rx_push) - 5'(rx_pop);
        if (rx_push)
        begin
            n.rxf[q.rxw] = rx_byte;
            n.rxw = q.rxw + 4'h1;
        end
        if (rx_pop)
        begin
            n.rxr = q.rxr + 4'h1;
        end
        // Flush wins over a push or pop in the same cycle
        if (tx_flush)
        begin
            n.txw = 4'h0;
            n.txr = 4'h0;
            n.txn = 5'h00;
        end
        if (rx_flush)
        begin
            n.rxw = 4'h0;
            n.rxr = 4'h0;
            n.rxn = 5'h00;
        end

        // Character timeout
        if (rx_push || rx_pop || !q.fen || q.rxn == 5'h00 || q.rx_st != SER_IDLE)
        begin
            n.tmo = 10'h000;
        end
        else if (tick && q.tmo != TMO_TICKS)
        begin
            n.tmo = q.tmo + 10'h001;
        end

        // Sticky events, set wins over read clear
        if (tx_pop && q.txn == 5'h01 && !tx_push)
        begin
            n.sts[EV_THRE] = 1'b1;
        end
        if (rx_push && (!q.fen || n.rxn == trig_lvl))
        begin
            n.sts[EV_RXD] = 1'b1;
        end
        if (tick && q.tmo == TMO_TICKS - 10'h001)
        begin
            n.sts[EV_TMO] = 1'b1;
        end
        if (n.pe && !q.pe || n.fe && !q.fe || n.oe && !q.oe)
        begin
            n.sts[EV_LSE] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            q <= '0;
            q.lcr <= LCR_RST;
            q.div <= DIV_RST;
            q.txd <= 1'b1;
            q.rx_h <= 1'b1;
            q.rx_f <= 1'b1;
        end
        else
        begin
            q <= n;
        end
    end

endmodule // fub_uart

/* File: sim/fub_uart_monitor.sv */
module fub_uart_monitor
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Serial line
    input wire logic txd
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----------------
    // Bus
    // ----------------
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    ar_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
    r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data not released");
    // ----------------
    // Serial line
    // ----------------
    tx_start_a: assert property ($fell(txd) |-> !txd [*8])
        else $error("start bit too short");
    tx_bit_a: assert property ($changed(txd) |=> $stable(txd) [*8])
        else $error("serial bit too short");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($fell(txd));
endmodule // fub_uart_monitor

bind fub_uart fub_uart_monitor mon (.*);

/* File: sim/fub_serial_model.sv */
module fub_serial_model
(
    // Clock
    input wire logic aclk,
    // Serial lines
    input wire logic txd,
    output logic rxd = 1'b1,
    // Bit length in cycles
    input wire integer bitc
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [9:0] raw;
    int cnt = 0;
    // Capture of frames from the device
    always
    begin
        @(negedge txd);
        repeat (bitc / 2) @(posedge aclk);
        for (int i = 0; i < 10; i++)
        begin
            raw[i] = txd;
            if (i < 9) repeat (bitc) @(posedge aclk);
        end
        cnt++;
    end
    // Frame drive towards the device
    task automatic send(input logic [10:0] f, input int n, input int len);
        for (int i = 0; i < n; i++)
        begin
            @(posedge aclk);
            rxd <= f[i];
            repeat (len - 1) @(posedge aclk);
        end
        @(posedge aclk);
        rxd <= 1'b1;
    endtask
endmodule // fub_serial_model

/* File: sim/fub_uart_tb_top.sv */
module fub_uart_tb_top
    import fub_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic src24_tick, src16_tick, rxd, txd, irq;
    logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    int bitc, n_mismatch, num_checks;
    fub_uart dut (.*);
    fub_serial_model p (.*);
    initial
    begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) src16_tick <= aresetn ? ~src16_tick : 1'b0;
    // ----------------
    // Bus tasks
    // ----------------
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (aw || w)
        begin
            @(posedge aclk);
            if (s_axi_awready) aw = 1'b0;
            if (s_axi_wready) w = 1'b0;
            if (!aw) s_axi_awvalid <= 1'b0;
            if (!w) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        v = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        rd(a);
        check(v, e);
    endtask
    task automatic waitf(input int n);
        while (p.cnt < n) @(posedge aclk);
    endtask
    task automatic final_report;
        $display("Comparisons: %0d, mismatches: %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // ----------------
    // Tests
    // ----------------
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        src24_tick = 1'b1;
        aresetn = 1'b0;
        bitc = 16;
        n_mismatch = 0;
        num_checks = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(5'h0C, 32'h3);
        rdc(5'h14, 32'h1);
        rd(5'h1C);
        check(r, RESP_DEC);
        wr(5'h1C, 32'h0);
        check(r, RESP_DEC);
        wr(5'h00, 32'hA5);
        waitf(1);
        check(p.raw, {1'b1, 8'hA5, 1'b0});
        check(irq, 1'b0);
        wr(5'h04, 32'h1);
        check(irq, 1'b1);
        rdc(5'h18, 32'h1);
        check(irq, 1'b0);
        wr(5'h04, 32'h0);
        wr(5'h0C, 32'h1A);
        wr(5'h00, 32'h5B);
        waitf(2);
        check(p.raw, {1'b1, ^7'h5B, 7'h5B, 1'b0});
        bitc = 48;
        wr(5'h0C, 32'h03);
        wr(5'h14, 32'h3);
        wr(5'h00, 32'hC3);
        waitf(3);
        check(p.raw, {1'b1, 8'hC3, 1'b0});
        bitc = 32;
        wr(5'h14, 32'h1);
        wr(5'h0C, 32'h83);
        wr(5'h00, 32'h96);
        waitf(4);
        check(p.raw, {1'b1, 8'h96, 1'b0});
        bitc = 16;
        wr(5'h0C, 32'h03);
        wr(5'h08, 32'h01);
        for (int i = 1; i < 4; i++) wr(5'h00, 32'h11 * i);
        waitf(7);
        check(p.raw, {1'b1, 8'h33, 1'b0});
        wr(5'h08, 32'h00);
        wr(5'h04, 32'h2);
        rd(5'h18);
        p.send({1'b1, 8'h3C, 1'b0}, 10, 16);
        while (!irq) @(posedge aclk);
        rdc(5'h18, 32'h2);
        rdc(5'h00, 32'h3C);
        p.send(11'h0, 1, 1);
        repeat (100) @(posedge aclk);
        rdc(5'h10, 32'h60);
        wr(5'h0C, 32'h1B);
        wr(5'h04, 32'hF);
        p.send({2'b11, 8'h3C, 1'b0}, 11, 16);
        rdc(5'h08, 32'h6);
        rdc(5'h10, 32'h65);
        rd(5'h00);
        rd(5'h18);
        rdc(5'h08, 32'h1);
        wr(5'h0C, 32'h03);
        wr(5'h08, 32'h41);
        for (int i = 0; i < 4; i++)
        begin
            p.send({1'b1, 8'h40 + 8'(i), 1'b0}, 10, 16);
            rd(5'h18);
            check(v[1], i == 3);
        end
        repeat (700) @(posedge aclk);
        rdc(5'h18, 32'h4);
        wr(5'h0C, 32'h3A);
        wr(5'h00, 32'h5B);
        waitf(8);
        check(p.raw, {1'b1, 1'b0, 7'h5B, 1'b0});
        final_report();
    end
    initial
    begin
        repeat (30000) @(posedge aclk);
        n_mismatch++;
        final_report();
    end
endmodule // fub_uart_tb_top
